// ==== dda_alarm_sva.sv ====
/*
 * Checker of the dual display alarm: bus handshakes, reset state and
 * display alternation, seen only at the top module's ports.
 * Assumes binding to dda_alarm_top on its single clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dda_regs.vh"

module dda_alarm_checker (
  input wire ref_clk,
  input wire resetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire switchClosed1_q,
  input wire annunciator1_q,
  input wire annunciator2_q,
  input wire [1:0] displaySource_q,
  input wire irq_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence writeTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence readTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence tagOneShown;
    displaySource_q == `DDA_SRC_TAG1;
  endsequence

  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready longer than one cycle");
  write_answer_a: assert property (writeTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (readTaken |=> s_axi_rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  reset_idle_a: assert property ($rose(resetn) |-> !switchClosed1_q
    && !annunciator1_q && !annunciator2_q && !irq_q
    && displaySource_q == `DDA_SRC_VALUE)
    else $error("outputs not idle after reset");
  source_legal_a: assert property (displaySource_q != 2'h3)
    else $error("display source code unused");
  tag_lit_a: assert property (tagOneShown |-> annunciator1_q
    || $past(annunciator1_q))
    else $error("tag one shown without alarm");
  tag_two_lit_a: assert property (displaySource_q == `DDA_SRC_TAG2
    |-> annunciator2_q || $past(annunciator2_q))
    else $error("tag two shown without alarm");
  tag_step_a: assert property (tagOneShown ##1
    displaySource_q != `DDA_SRC_TAG1 |-> displaySource_q == `DDA_SRC_VALUE)
    else $error("tag one not followed by value");
endmodule // dda_alarm_checker

bind dda_alarm_top dda_alarm_checker i_chk (.*);
`default_nettype wire

// ==== dda_alarm_top.v ====
/*
 * Dual display alarm: AXI4-Lite registers, timebase, two channels,
 * switch and annunciator drive, display alternation and interrupt.
 * Assumes displayValue comes from same-clock scaling logic, already
 * scaled and tared; acceptButton is a raw active-high panel pin.
 */
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dda_regs.vh"

module dda_alarm_top #(
  parameter TICK_CYCLES = `DDA_TICK_CYCLES
) (
  input wire ref_clk,
  input wire resetn,
  input wire [`DDA_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`DDA_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] displayValue,
  input wire acceptButton,
  output reg switchClosed1_q,
  output reg switchClosed2_q,
  output reg annunciator1_q,
  output reg annunciator2_q,
  output reg [1:0] displaySource_q,
  output reg irq_q
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [`DDA_CTRL_W-1:0] ctrl_q;
  reg [31:0] sp1_q;
  reg [31:0] sp2_q;
  reg [`DDA_HYST_W-1:0] hyst1_q;
  reg [`DDA_HYST_W-1:0] hyst2_q;
  reg [`DDA_TIME_W-1:0] delay1_q;
  reg [`DDA_TIME_W-1:0] delay2_q;
  reg [`DDA_TIME_W-1:0] sil1_q;
  reg [`DDA_TIME_W-1:0] sil2_q;
  reg [`DDA_INT_W-1:0] intStat_q;
  reg [`DDA_INT_W-1:0] intMask_q;

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  reg awHeld_q;
  reg wHeld_q;
  reg [`DDA_ADDR_W-1:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  wire doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  reg wrHit;
  reg [`DDA_INT_W-1:0] intClear;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  function [`DDA_TIME_W-1:0] clampTime;
    input [31:0] data;
    begin
      // longer than the documented range saturates at the top value
      if (data > {20'h00000, `DDA_TIME_MAX}) begin
        clampTime = `DDA_TIME_MAX;
      end else begin
        clampTime = data[`DDA_TIME_W-1:0];
      end
    end
  endfunction

  wire [31:0] ctrlMerged = merge({25'h0, ctrl_q}, wData_q, wStrb_q);
  wire [31:0] hyst1Merged = merge({16'h0, hyst1_q}, wData_q, wStrb_q);
  wire [31:0] hyst2Merged = merge({16'h0, hyst2_q}, wData_q, wStrb_q);
  wire [31:0] maskMerged = merge({28'h0, intMask_q}, wData_q, wStrb_q);

  always @(posedge ref_clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= {`DDA_ADDR_W{1'b0}};
      wData_q <= `DDA_WORD_RST;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DDA_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `DDA_RESP_OKAY : `DDA_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    case (awAddr_q)
      `DDA_OFF_CTRL, `DDA_OFF_SP1, `DDA_OFF_SP2, `DDA_OFF_HYST1,
      `DDA_OFF_HYST2, `DDA_OFF_DELAY1, `DDA_OFF_DELAY2,
      `DDA_OFF_SIL1, `DDA_OFF_SIL2, `DDA_OFF_STATUS,
      `DDA_OFF_INTSTAT, `DDA_OFF_INTMASK, `DDA_OFF_DISPLAY:
        wrHit = 1'b1;
      default:
        wrHit = 1'b0;
    endcase
    intClear = {`DDA_INT_W{1'b0}};
    if (doWrite && awAddr_q == `DDA_OFF_INTSTAT && wStrb_q[0]) begin
      intClear = wData_q[`DDA_INT_W-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_q <= `DDA_CTRL_RST;
      sp1_q <= `DDA_WORD_RST;
      sp2_q <= `DDA_WORD_RST;
      hyst1_q <= {`DDA_HYST_W{1'b0}};
      hyst2_q <= {`DDA_HYST_W{1'b0}};
      delay1_q <= {`DDA_TIME_W{1'b0}};
      delay2_q <= {`DDA_TIME_W{1'b0}};
      sil1_q <= {`DDA_TIME_W{1'b0}};
      sil2_q <= {`DDA_TIME_W{1'b0}};
      intMask_q <= `DDA_INT_RST;
    end else if (doWrite) begin
      case (awAddr_q)
        `DDA_OFF_CTRL: ctrl_q <= ctrlMerged[`DDA_CTRL_W-1:0];
        `DDA_OFF_SP1: sp1_q <= merge(sp1_q, wData_q, wStrb_q);
        `DDA_OFF_SP2: sp2_q <= merge(sp2_q, wData_q, wStrb_q);
        `DDA_OFF_HYST1: hyst1_q <= hyst1Merged[`DDA_HYST_W-1:0];
        `DDA_OFF_HYST2: hyst2_q <= hyst2Merged[`DDA_HYST_W-1:0];
        `DDA_OFF_DELAY1:
          delay1_q <= clampTime(merge({20'h0, delay1_q}, wData_q,
                                      wStrb_q));
        `DDA_OFF_DELAY2:
          delay2_q <= clampTime(merge({20'h0, delay2_q}, wData_q,
                                      wStrb_q));
        `DDA_OFF_SIL1:
          sil1_q <= clampTime(merge({20'h0, sil1_q}, wData_q,
                                    wStrb_q));
        `DDA_OFF_SIL2:
          sil2_q <= clampTime(merge({20'h0, sil2_q}, wData_q,
                                    wStrb_q));
        `DDA_OFF_INTMASK: intMask_q <= maskMerged[`DDA_INT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  reg [31:0] rdMux;
  reg rdHit;
  wire [1:0] st1;
  wire [1:0] st2;
  wire cond1;
  wire cond2;
  wire act1Pulse;
  wire act2Pulse;
  wire out1 = (st1 == `DDA_ST_ACTIVE);
  wire out2 = (st2 == `DDA_ST_ACTIVE);

  always @* begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      `DDA_OFF_CTRL: rdMux = {25'h0, ctrl_q};
      `DDA_OFF_SP1: rdMux = sp1_q;
      `DDA_OFF_SP2: rdMux = sp2_q;
      `DDA_OFF_HYST1: rdMux = {16'h0, hyst1_q};
      `DDA_OFF_HYST2: rdMux = {16'h0, hyst2_q};
      `DDA_OFF_DELAY1: rdMux = {20'h0, delay1_q};
      `DDA_OFF_DELAY2: rdMux = {20'h0, delay2_q};
      `DDA_OFF_SIL1: rdMux = {20'h0, sil1_q};
      `DDA_OFF_SIL2: rdMux = {20'h0, sil2_q};
      `DDA_OFF_STATUS:
        rdMux = {24'h0, st2, st1, out2, out1, cond2, cond1};
      `DDA_OFF_INTSTAT: rdMux = {28'h0, intStat_q};
      `DDA_OFF_INTMASK: rdMux = {28'h0, intMask_q};
      `DDA_OFF_DISPLAY: rdMux = {30'h0, displaySource_q};
      default: begin
        rdMux = `DDA_WORD_RST;
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `DDA_WORD_RST;
      s_axi_rresp <= `DDA_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                       s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? `DDA_RESP_OKAY : `DDA_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // timebase: one-second tick and half-second blink
  // ----------------------------------------------------------------
  reg [31:0] tickCount_q;
  reg tick_q;
  reg blink_q;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  localparam [31:0] TICK_HALF = TICK_CYCLES / 2;

  always @(posedge ref_clk) begin
    if (!resetn) begin
      tickCount_q <= `DDA_WORD_RST;
      tick_q <= 1'b0;
      blink_q <= 1'b0;
    end else begin
      tick_q <= (tickCount_q == TICK_LAST);
      if (tickCount_q == TICK_LAST) begin
        tickCount_q <= `DDA_WORD_RST;
        blink_q <= 1'b1;
      end else begin
        tickCount_q <= tickCount_q + 1'b1;
        if (tickCount_q == TICK_HALF) begin
          blink_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // accept button: synchroniser and rising edge
  // ----------------------------------------------------------------
  reg btnMeta_q;
  reg btnSync_q;
  reg btnLast_q;
  reg accept_q;

  always @(posedge ref_clk) begin
    if (!resetn) begin
      btnMeta_q <= 1'b0;
      btnSync_q <= 1'b0;
      btnLast_q <= 1'b0;
      accept_q <= 1'b0;
    end else begin
      btnMeta_q <= acceptButton;
      btnSync_q <= btnMeta_q;
      btnLast_q <= btnSync_q;
      accept_q <= btnSync_q && !btnLast_q;
    end
  end

  // ----------------------------------------------------------------
  // the two channels
  // ----------------------------------------------------------------
  dda_channel chan1 (
    .clk(ref_clk),
    .resetn(resetn),
    .tick(tick_q),
    .enable(ctrl_q[`DDA_CTRL_EN1]),
    .highLow(ctrl_q[`DDA_CTRL_HL1]),
    .accept(accept_q),
    .value(displayValue),
    .setpoint(sp1_q),
    .hyst(hyst1_q),
    .delay(delay1_q),
    .silence(sil1_q),
    .condition_q(cond1),
    .state_q(st1),
    .activated_q(act1Pulse)
  );

  dda_channel chan2 (
    .clk(ref_clk),
    .resetn(resetn),
    .tick(tick_q),
    .enable(ctrl_q[`DDA_CTRL_EN2]),
    .highLow(ctrl_q[`DDA_CTRL_HL2]),
    .accept(accept_q),
    .value(displayValue),
    .setpoint(sp2_q),
    .hyst(hyst2_q),
    .delay(delay2_q),
    .silence(sil2_q),
    .condition_q(cond2),
    .state_q(st2),
    .activated_q(act2Pulse)
  );

  // ----------------------------------------------------------------
  // switches, annunciators, display alternation
  // ----------------------------------------------------------------
  reg [1:0] altStep_q;
  reg cond1Last_q;
  reg cond2Last_q;
  wire pend1 = (st1 == `DDA_ST_DELAY) || (st1 == `DDA_ST_SILENCE);
  wire pend2 = (st2 == `DDA_ST_DELAY) || (st2 == `DDA_ST_SILENCE);
  reg [1:0] srcD;

  always @* begin
    srcD = `DDA_SRC_VALUE;
    if (ctrl_q[`DDA_CTRL_FLASH]) begin
      // odd steps show a tag; each tag only while its output drives
      if (altStep_q == 2'h1 && out1) begin
        srcD = `DDA_SRC_TAG1;
      end else if (altStep_q == 2'h3 && out2) begin
        srcD = `DDA_SRC_TAG2;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      switchClosed1_q <= 1'b0;
      switchClosed2_q <= 1'b0;
      annunciator1_q <= 1'b0;
      annunciator2_q <= 1'b0;
      displaySource_q <= `DDA_SRC_VALUE;
      altStep_q <= 2'h0;
      intStat_q <= `DDA_INT_RST;
      cond1Last_q <= 1'b0;
      cond2Last_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      // a closed idle sense means alarm opens the switch, the fail-safe
      switchClosed1_q <= out1 ^ ctrl_q[`DDA_CTRL_NC1];
      switchClosed2_q <= out2 ^ ctrl_q[`DDA_CTRL_NC2];
      annunciator1_q <= out1 || (pend1 && blink_q);
      annunciator2_q <= out2 || (pend2 && blink_q);
      if (tick_q) begin
        altStep_q <= altStep_q + 1'b1;
      end
      displaySource_q <= srcD;
      cond1Last_q <= cond1;
      cond2Last_q <= cond2;
      // a new event wins over a clear in the same cycle
      intStat_q <= (intStat_q & ~intClear) |
                   {cond2 && !cond2Last_q, cond1 && !cond1Last_q,
                    act2Pulse, act1Pulse};
      irq_q <= |(intStat_q & intMask_q);
    end
  end

endmodule // dda_alarm_top
`default_nettype wire

// ==== dda_channel.v ====
/*
 * One alarm channel: hysteresis comparator, delay and silence timers.
 * Assumes a one-cycle tick each second and a clean one-cycle accept
 * pulse, both on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dda_regs.vh"

module dda_channel (
  input wire clk,
  input wire resetn,
  input wire tick,
  input wire enable,
  input wire highLow,
  input wire accept,
  input wire [31:0] value,
  input wire [31:0] setpoint,
  input wire [`DDA_HYST_W-1:0] hyst,
  input wire [`DDA_TIME_W-1:0] delay,
  input wire [`DDA_TIME_W-1:0] silence,
  output reg condition_q,
  output reg [1:0] state_q,
  output reg activated_q
);

  reg [`DDA_TIME_W-1:0] count_q;
  wire signed [32:0] valueExt = {value[31], value};
  wire signed [32:0] spExt = {setpoint[31], setpoint};
  wire signed [32:0] hystExt = {17'h00000, hyst};
  wire signed [32:0] clearBelow = spExt - hystExt;
  wire signed [32:0] clearAbove = spExt + hystExt;
  wire condD;

  // thresholds are stored display values, so a tare shift in value
  // moves the trip current, not the trip reading
  assign condD = highLow ?
    (condition_q ? (valueExt >= clearBelow)
                 : (valueExt >= spExt))
  : (condition_q ? (valueExt <= clearAbove)
                 : (valueExt <= spExt));

  always @(posedge clk) begin
    activated_q <= 1'b0;
    if (!resetn || !enable) begin
      state_q <= `DDA_ST_IDLE;
      count_q <= {`DDA_TIME_W{1'b0}};
      condition_q <= 1'b0;
    end else begin
      condition_q <= condD;
      case (state_q)
        `DDA_ST_IDLE: begin
          if (condition_q) begin
            if (delay == {`DDA_TIME_W{1'b0}}) begin
              state_q <= `DDA_ST_ACTIVE;
              activated_q <= 1'b1;
            end else begin
              state_q <= `DDA_ST_DELAY;
              count_q <= delay;
            end
          end
        end
        `DDA_ST_DELAY: begin
          // any dropout restarts the wait: persistence must be unbroken
          if (!condition_q) begin
            state_q <= `DDA_ST_IDLE;
          end else if (tick) begin
            // one tick past zero: a partial first second never shortens it
            if (count_q == {`DDA_TIME_W{1'b0}}) begin
              state_q <= `DDA_ST_ACTIVE;
              activated_q <= 1'b1;
            end else begin
              count_q <= count_q - 1'b1;
            end
          end
        end
        `DDA_ST_ACTIVE: begin
          if (!condition_q) begin
            state_q <= `DDA_ST_IDLE;
          end else if (accept && silence != {`DDA_TIME_W{1'b0}}) begin
            state_q <= `DDA_ST_SILENCE;
            count_q <= silence;
          end
        end
        `DDA_ST_SILENCE: begin
          if (!condition_q) begin
            state_q <= `DDA_ST_IDLE;
          end else if (tick) begin
            if (count_q == {`DDA_TIME_W{1'b0}}) begin
              state_q <= `DDA_ST_ACTIVE;
              activated_q <= 1'b1;
            end else begin
              count_q <= count_q - 1'b1;
            end
          end
        end
        default: begin
          state_q <= `DDA_ST_IDLE;
        end
      endcase
    end
  end

endmodule // dda_channel
`default_nettype wire

// ==== dda_regs.vh ====
/*
 * Constants of the dual display alarm block: register offsets, field
 * positions, reset values, channel states and timebase figures.
 * Assumes inclusion by bare name from every design file of the block.
 */
// What this block does
// - two identical channels, each high or low
// - output sense picks open or closed idle
// - annunciator lit while its channel alarms
// - flash option alternates value and channel tag
// - compare scaled displayed value, not current
// - tare never moves the alarm thresholds
// - condition true on reaching setpoint equality
// - enable gates alarm, keeps other settings
// - hysteresis in display units before clearing
// - delay between condition and output activation
// - accept holds output idle for silence time
// - clear below setpoint-hyst, or above setpoint+hyst
// - delay 0..3600 s, continuous, annunciator flashes
// - silence expiry reactivates; annunciator flashes meanwhile
// - alternation only while outputs active, both sequenced
`ifndef DDA_REGS_VH
`define DDA_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DDA_ADDR_W 8
`define DDA_OFF_CTRL 8'h00
`define DDA_OFF_SP1 8'h04
`define DDA_OFF_SP2 8'h08
`define DDA_OFF_HYST1 8'h0C
`define DDA_OFF_HYST2 8'h10
`define DDA_OFF_DELAY1 8'h14
`define DDA_OFF_DELAY2 8'h18
`define DDA_OFF_SIL1 8'h1C
`define DDA_OFF_SIL2 8'h20
`define DDA_OFF_STATUS 8'h24
`define DDA_OFF_INTSTAT 8'h28
`define DDA_OFF_INTMASK 8'h2C
`define DDA_OFF_DISPLAY 8'h30

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define DDA_CTRL_EN1 0
`define DDA_CTRL_EN2 1
`define DDA_CTRL_HL1 2
`define DDA_CTRL_HL2 3
`define DDA_CTRL_NC1 4
`define DDA_CTRL_NC2 5
`define DDA_CTRL_FLASH 6
`define DDA_CTRL_W 7
`define DDA_CTRL_RST 7'h00
`define DDA_INT_W 4
`define DDA_INT_RST 4'h0
`define DDA_HYST_W 16
`define DDA_TIME_W 12
`define DDA_TIME_MAX 12'hE10
`define DDA_WORD_RST 32'h00000000

// ----------------------------------------------------------------
// channel states and display sources
// ----------------------------------------------------------------
`define DDA_ST_IDLE 2'h0
`define DDA_ST_DELAY 2'h1
`define DDA_ST_ACTIVE 2'h2
`define DDA_ST_SILENCE 2'h3
`define DDA_SRC_VALUE 2'h0
`define DDA_SRC_TAG1 2'h1
`define DDA_SRC_TAG2 2'h2

// ----------------------------------------------------------------
// bus answers and timebase
// ----------------------------------------------------------------
`define DDA_RESP_OKAY 2'h0
`define DDA_RESP_SLVERR 2'h2
`define DDA_CLK_KHZ 10000
`define DDA_TICK_MS 1000
`define DDA_TICK_CYCLES (`DDA_TICK_MS * `DDA_CLK_KHZ)

`endif

// ==== dda_scale_model.sv ====
/*
 * Far side model: scaling path that hands the tared display value.
 * Assumes the alarm block's clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module dda_scale_model #(
  parameter int GAIN = 1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [31:0] rawReading,
  input wire logic [31:0] tareOffset,
  output var logic [31:0] displayValue_q
);
  // tare moves the display, never the setpoints behind it
  always @(posedge ref_clk) begin
    if (!resetn) begin
      displayValue_q <= 32'h00000000;
    end else begin
      displayValue_q <= rawReading * GAIN - tareOffset;
    end
  end
endmodule // dda_scale_model
`default_nettype wire

// ==== tb_top.sv ====
/*
 * Self-checking bench of the dual display alarm over AXI4-Lite.
 * Assumes the scaling model feeds displayValue on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dda_regs.vh"

module tb_top;
  localparam int TICK = 20;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic acceptButton = 1'b0;
  logic [31:0] rawReading = 32'h0;
  logic [31:0] tareOffset = 32'h0;
  logic [31:0] displayValue, s_axi_rdata, rdData;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, displaySource_q;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, switchClosed1_q, switchClosed2_q, irq_q;
  logic annunciator1_q, annunciator2_q;
  int failures = 0;
  int comparisons = 0;
  int n, hits, tags;

  always #50 ref_clk = ~ref_clk;

  dda_alarm_top #(.TICK_CYCLES(TICK)) i_dut (.*);
  dda_scale_model i_model (.ref_clk(ref_clk), .resetn(resetn),
    .rawReading(rawReading), .tareOffset(tareOffset),
    .displayValue_q(displayValue));

  // ----
  // bus tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  // response ready stands from the start; the answer edge ends the wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    if (k == 40) check("bus wait", 32'h0, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rdData = s_axi_rdata;
    rsp = s_axi_rresp;
    if (k == 40) check("bus wait", 32'h0, 32'h1);
  endtask
  task automatic raw(input logic [31:0] v);
    @(posedge ref_clk);
    rawReading <= v;
  endtask
  // pin order: switch one, annunciator one, switch two, irq
  task automatic pins(input string s, input logic [3:0] exp);
    step(6);
    check(s, {28'h0, switchClosed1_q, annunciator1_q, switchClosed2_q,
      irq_q}, {28'h0, exp});
  endtask
  task automatic waitOn();
    n = 0;
    hits = 0;
    while (switchClosed1_q !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
      hits += int'(annunciator1_q);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  initial begin
    step(12);
    resetn <= 1'b1;
    rd(`DDA_OFF_CTRL);
    check("ctrl reset", rdData, 32'h0);
    rd(`DDA_OFF_STATUS);
    check("status reset", rdData, 32'h0);
    rd(8'h40);
    check("rd unmapped", {30'h0, rsp}, {30'h0, `DDA_RESP_SLVERR});
    wr(8'h40, 32'h1);
    check("wr unmapped", {30'h0, rsp}, {30'h0, `DDA_RESP_SLVERR});
    $display("test registers done");
    wr(8'h04, 32'h000003E8);
    wr(`DDA_OFF_HYST1, 32'h000000C8);
    wr(`DDA_OFF_CTRL, 32'h00000005);
    raw(32'h000003E7);
    pins("below setpoint", 4'h0);
    raw(32'h000003E8);
    pins("at setpoint", 4'hC);
    wr(`DDA_OFF_INTMASK, 32'h00000001);
    pins("irq unmasked", 4'hD);
    rd(`DDA_OFF_INTSTAT);
    check("int status", rdData, 32'h00000005);
    wr(`DDA_OFF_INTSTAT, 32'h00000005);
    pins("irq cleared", 4'hC);
    wr(`DDA_OFF_INTMASK, 32'h0);
    raw(32'h00000320);
    pins("inside band", 4'hC);
    raw(32'h0000031F);
    pins("below band", 4'h0);
    wr(`DDA_OFF_CTRL, 32'h00000015);
    pins("closed idle", 4'h8);
    raw(32'h000003E8);
    pins("open in alarm", 4'h4);
    $display("test high alarm done");
    wr(8'h08, 32'h000001F4);
    wr(`DDA_OFF_CTRL, 32'h00000002);
    raw(32'h000002BC);
    pins("low idle", 4'h0);
    tareOffset <= 32'h000000C8;
    pins("tared trip", 4'h2);
    tareOffset <= 32'h0;
    pins("untared clear", 4'h0);
    $display("test low alarm done");
    wr(`DDA_OFF_DELAY1, 32'h00000003);
    wr(`DDA_OFF_CTRL, 32'h00000005);
    raw(32'h000003E8);
    waitOn();
    check("delay span", n > 3 * TICK && n < 4 * TICK + 8, 1);
    check("delay blink", hits > 5 && hits < n - 5, 1);
    wr(`DDA_OFF_SIL1, 32'h00000002);
    acceptButton <= 1'b1;
    step(5);
    acceptButton <= 1'b0;
    step(3);
    check("silenced", switchClosed1_q, 0);
    waitOn();
    check("silence span", n > 2 * TICK - 6 && n < 3 * TICK + 4, 1);
    check("silence blink", hits > 3 && hits < n - 3, 1);
    $display("test timers done");
    wr(`DDA_OFF_DELAY1, 32'h0);
    wr(`DDA_OFF_CTRL, 32'h0000004F);
    tags = 0;
    repeat (6 * TICK) begin
      @(posedge ref_clk);
      if (displaySource_q === `DDA_SRC_TAG1) tags |= 1;
      if (displaySource_q === `DDA_SRC_TAG2) tags |= 2;
    end
    check("both tags", tags, 3);
    wr(`DDA_OFF_CTRL, 32'h0000004E);
    step(4);
    check("ch1 off", {switchClosed1_q, annunciator1_q}, 0);
    check("ch2 kept", {switchClosed2_q, annunciator2_q}, 3);
    rd(8'h04);
    check("setpoint kept", rdData, 32'h000003E8);
    rd(`DDA_OFF_STATUS);
    check("ch1 cleared", rdData & 32'h00000035, 0);
    $display("test flash and disable done");
    summarize();
  end

  initial begin
    step(20000);
    failures++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
